//--- hdl/pwr_defines.svh
// constants of the power-down and wake-up controller
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH

// register map, byte addresses
`define ADDR_W 8
`define ADDR_CONFIG 8'h00
`define ADDR_STATUS 8'h04
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// config register fields
`define CFG_OSC_RC 0
`define CFG_WDT_EN 1
`define CFG_WDT_SRC_SYS 2
`define CFG_CLR_TWO 3
`define CFG_WDT_OSC_OFF 4
`define CFG_PA_WAKE_LO 8
`define CFG_RESET 32'h0000_0002

// status register fields
`define ST_PDF 0
`define ST_TO 1
`define ST_STATE_LO 4
`define ST_WAKE_LO 8
`define ST_SVC 12

// widths
`define PA_W 8
`define INT_W 4
`define WDT_PRE_W 15

// restart delay in system clock periods; the block clock is the system clock
`define RESTART_PERIODS 1024
`define RESTART_CYCLES (`RESTART_PERIODS)
`define RESTART_LAST 10'h3FF

`endif

//--- hdl/pwr_pkg.sv
// types of the power-down and wake-up controller
package pwr_pkg;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_HALT = 2'b01,
      ST_RESTART = 2'b10
   } pwr_state_t;

   typedef enum logic [2:0] {
      WAKE_NONE = 3'b000,
      WAKE_EXT_RESET = 3'b001,
      WAKE_PORT_A = 3'b010,
      WAKE_INT = 3'b011,
      WAKE_WDT = 3'b100
   } wake_src_t;
endpackage

//--- hdl/pin_edge_sync.sv
// two-stage pin synchroniser with edge pulses
`timescale 1ns/100ps
module pin_edge_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // pins
   input wire logic [W-1:0] i_pin,
   // synchronised level and edges
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_fall,
   output logic [W-1:0] o_rise
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   // idle-high pins, so no false edge out of reset
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         meta_r <= {W{1'b1}};
         sync_r <= {W{1'b1}};
         prev_r <= {W{1'b1}};
      end
      else
      begin
         meta_r <= i_pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign o_level = sync_r;
   assign o_fall = prev_r & ~sync_r;
   assign o_rise = ~prev_r & sync_r;
endmodule

//--- hdl/power_down_wakeup_control.sv
// power-down, wake-up, restart delay, watchdog and clock source control
// =============================================================
// Notes on behaviour
// - clock from crystal or RC, by option
// - RC mode drives clock/4 open-drain on pin
// - clock stops in halt; watchdog oscillator runs
// - option switches watchdog oscillator off
// - only halt enters power-down; program holds
// - state, memory and ports kept while halted
// - halt clears watchdog; runs only on own oscillator
// - halt sets power-down flag, clears timeout flag
// - four wake sources: reset, pin, interrupt, watchdog
// - reset wake: full reset; watchdog wake: watchdog reset
// - watchdog wake sets timeout, resets only PC/SP
// - power-up or watchdog clear clears power-down flag
// - per-pin option enables Port A falling-edge wake
// - pin wake resumes after halt
// - disabled or stack-full interrupt resumes after halt
// - enabled interrupt with free stack is serviced
// - interrupt pending at halt cannot wake
// - 1024 clock wait after wake, then next instruction
// - service routine starts a cycle after the wait
// - flags 1/1 after halt timeout, 0/0 power-on
`timescale 1ns/100ps
`include "pwr_defines.svh"
module power_down_wakeup_control (
   // clock and power-on reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESET_N,
   // axi4-lite slave
   input wire logic [`ADDR_W-1:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [`ADDR_W-1:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // pins
   input wire logic I_EXTERNAL_RESET_PIN_N,
   input wire logic [`PA_W-1:0] I_PORT_A_PIN,
   input wire logic I_WDT_OSC,
   output logic O_OSCILLATOR_OUTPUT_PIN,
   output logic O_OSCILLATOR_OUTPUT_PIN_OE,
   // cpu core events and interrupt state
   input wire logic I_HALT_EXEC,
   input wire logic I_CLR_WDT1_EXEC,
   input wire logic I_CLR_WDT2_EXEC,
   input wire logic [`INT_W-1:0] I_INT_REQ,
   input wire logic [`INT_W-1:0] I_INT_EN,
   input wire logic I_STACK_FULL,
   // clock and execution control
   output logic O_OSC_SEL_RC,
   output logic O_SYS_CLK_EN,
   output logic O_WDT_OSC_EN,
   output logic O_CPU_RUN,
   output logic O_SYS_RESET,
   output logic O_PC_SP_RESET,
   output logic O_RESUME,
   output logic O_INT_ACCEPT,
   // status flags
   output logic O_POWER_DOWN_FLAG,
   output logic O_TIMEOUT_FLAG
);
   // =============================================================
   // declarations
   pwr_pkg::pwr_state_t state_r;
   pwr_pkg::wake_src_t wake_r;
   logic [31:0] cfg_r;
   logic aw_got_r, w_got_r;
   logic [`ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_en;
   logic [`PA_W-1:0] pa_fall;
   logic rst_level;
   logic wdt_osc_level, rst_rise;
   logic wdt_osc_rise;
   logic [1:0] div_r;
   logic [`WDT_PRE_W-1:0] wdt_pre_r;
   logic wdt_top_r;
   logic wdt_tick, wdt_ovf, wdt_clear;
   logic clr1_seen_r, clr2_seen_r, clr_done;
   logic pdf_r, to_r;
   logic [`INT_W-1:0] int_mask_r;
   logic [`INT_W-1:0] int_wake;
   logic pa_wake, halt_take;
   logic [9:0] rs_cnt_r;
   logic svc_r;
   logic sys_rst_r, pcsp_rst_r, resume_r, int_acc_r;

   // set wins over a clear arriving in the same cycle
   function automatic logic flag_next(input logic cur, input logic set, input logic clr);
      flag_next = set | (cur & ~clr);
   endfunction

   // =============================================================
   // pin synchronisers
   pin_edge_sync #(.W(`PA_W)) u_pa_sync (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RESET_N),
      .i_pin(I_PORT_A_PIN),
      .o_level(),
      .o_fall(pa_fall),
      .o_rise()
   );

   pin_edge_sync #(.W(2)) u_misc_sync (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RESET_N),
      .i_pin({I_EXTERNAL_RESET_PIN_N, I_WDT_OSC}),
      .o_level({rst_level, wdt_osc_level}),
      .o_fall(),
      .o_rise({rst_rise, wdt_osc_rise})
   );

   // =============================================================
   // axi4-lite slave
   assign O_AWREADY = !aw_got_r && !O_BVALID;
   assign O_WREADY = !w_got_r && !O_BVALID;
   assign O_ARREADY = !O_RVALID;
   assign wr_en = aw_got_r && w_got_r;

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         O_BVALID <= 1'b0;
         O_BRESP <= `RESP_OKAY;
      end
      else
      begin
         if (I_AWVALID && O_AWREADY)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= I_AWADDR;
         end
         if (I_WVALID && O_WREADY)
         begin
            w_got_r <= 1'b1;
            wdata_r <= I_WDATA;
            wstrb_r <= I_WSTRB;
         end
         if (wr_en)
         begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            O_BVALID <= 1'b1;
            O_BRESP <= (awaddr_r == `ADDR_CONFIG) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (O_BVALID && I_BREADY)
         begin
            O_BVALID <= 1'b0;
         end
      end
   end

   // option bits; software plays the programmer here
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         cfg_r <= `CFG_RESET;
      end
      else if (wr_en && awaddr_r == `ADDR_CONFIG)
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (wstrb_r[b])
            begin
               cfg_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         O_RVALID <= 1'b0;
         O_RDATA <= '0;
         O_RRESP <= `RESP_OKAY;
      end
      else if (I_ARVALID && O_ARREADY)
      begin
         O_RVALID <= 1'b1;
         O_RRESP <= `RESP_OKAY;
         O_RDATA <= '0;
         if (I_ARADDR == `ADDR_CONFIG)
         begin
            O_RDATA <= {16'h0000, cfg_r[15:0]};
         end
         else if (I_ARADDR == `ADDR_STATUS)
         begin
            O_RDATA[`ST_PDF] <= pdf_r;
            O_RDATA[`ST_TO] <= to_r;
            O_RDATA[`ST_STATE_LO +: 2] <= state_r;
            O_RDATA[`ST_WAKE_LO +: 3] <= wake_r;
            O_RDATA[`ST_SVC] <= svc_r;
         end
         else
         begin
            O_RRESP <= `RESP_SLVERR;
         end
      end
      else if (O_RVALID && I_RREADY)
      begin
         O_RVALID <= 1'b0;
      end
   end

   // =============================================================
   // clock source and divided clock output
   assign O_OSC_SEL_RC = cfg_r[`CFG_OSC_RC];
   assign O_SYS_CLK_EN = (state_r != pwr_pkg::ST_HALT);
   assign O_WDT_OSC_EN = !cfg_r[`CFG_WDT_OSC_OFF];
   assign O_OSCILLATOR_OUTPUT_PIN = 1'b0;
   // open drain: pull low for half of each four-clock period
   assign O_OSCILLATOR_OUTPUT_PIN_OE = cfg_r[`CFG_OSC_RC] && O_SYS_CLK_EN && !div_r[1];

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         div_r <= 2'h0;
      end
      else if (O_SYS_CLK_EN)
      begin
         div_r <= div_r + 2'h1;
      end
   end

   // =============================================================
   // watchdog: 15-bit prescaler plus a clearable last stage
   assign wdt_tick = cfg_r[`CFG_WDT_EN] &&
      (cfg_r[`CFG_WDT_SRC_SYS] ? (O_SYS_CLK_EN && div_r == 2'h3)
                               : (O_WDT_OSC_EN && wdt_osc_rise));
   assign wdt_ovf = wdt_tick && wdt_top_r && (&wdt_pre_r);
   assign clr_done = cfg_r[`CFG_CLR_TWO]
      ? ((I_CLR_WDT1_EXEC || clr1_seen_r) && (I_CLR_WDT2_EXEC || clr2_seen_r))
      : (I_CLR_WDT1_EXEC || I_CLR_WDT2_EXEC);
   assign halt_take = I_HALT_EXEC && state_r == pwr_pkg::ST_RUN && rst_level;
   assign wdt_clear = halt_take || clr_done || !rst_level;

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N || clr_done || !cfg_r[`CFG_CLR_TWO])
      begin
         clr1_seen_r <= 1'b0;
         clr2_seen_r <= 1'b0;
      end
      else
      begin
         clr1_seen_r <= clr1_seen_r | I_CLR_WDT1_EXEC;
         clr2_seen_r <= clr2_seen_r | I_CLR_WDT2_EXEC;
      end
   end

   // only the last stage clears, so a timeout spans one to two wraps
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         wdt_pre_r <= '0;
         wdt_top_r <= 1'b0;
      end
      else
      begin
         if (wdt_tick)
         begin
            wdt_pre_r <= wdt_pre_r + 15'h0001;
         end
         if (wdt_clear)
         begin
            wdt_top_r <= 1'b0;
         end
         else if (wdt_tick && (&wdt_pre_r))
         begin
            wdt_top_r <= !wdt_top_r;
         end
      end
   end

   // =============================================================
   // status flags; external reset leaves both unchanged
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         pdf_r <= 1'b0;
         to_r <= 1'b0;
      end
      else
      begin
         pdf_r <= flag_next(pdf_r, halt_take, clr_done);
         to_r <= flag_next(to_r, wdt_ovf, halt_take);
      end
   end

   assign O_POWER_DOWN_FLAG = pdf_r;
   assign O_TIMEOUT_FLAG = to_r;

   // =============================================================
   // wake sources
   assign pa_wake = |(pa_fall & cfg_r[`CFG_PA_WAKE_LO +: `PA_W]);
   assign int_wake = I_INT_REQ & ~int_mask_r;

   // requests already pending at halt are barred from waking
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         int_mask_r <= '0;
      end
      else if (halt_take)
      begin
         int_mask_r <= I_INT_REQ;
      end
   end

   // =============================================================
   // power state machine; the core holds everything while halted
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         state_r <= pwr_pkg::ST_RESTART;
         wake_r <= pwr_pkg::WAKE_NONE;
         svc_r <= 1'b0;
         rs_cnt_r <= '0;
      end
      else if (!rst_level)
      begin
         state_r <= pwr_pkg::ST_RESTART;
         wake_r <= pwr_pkg::WAKE_EXT_RESET;
         svc_r <= 1'b0;
         rs_cnt_r <= '0;
      end
      else
      begin
         unique case (state_r)
            pwr_pkg::ST_RUN:
            begin
               if (wdt_ovf)
               begin
                  state_r <= pwr_pkg::ST_RESTART;
                  rs_cnt_r <= '0;
               end
               else if (halt_take)
               begin
                  state_r <= pwr_pkg::ST_HALT;
                  wake_r <= pwr_pkg::WAKE_NONE;
                  svc_r <= 1'b0;
               end
            end
            pwr_pkg::ST_HALT:
            begin
               rs_cnt_r <= '0;
               if (wdt_ovf)
               begin
                  state_r <= pwr_pkg::ST_RESTART;
                  wake_r <= pwr_pkg::WAKE_WDT;
               end
               else if (pa_wake)
               begin
                  state_r <= pwr_pkg::ST_RESTART;
                  wake_r <= pwr_pkg::WAKE_PORT_A;
               end
               else if (|int_wake)
               begin
                  state_r <= pwr_pkg::ST_RESTART;
                  wake_r <= pwr_pkg::WAKE_INT;
                  svc_r <= (|(int_wake & I_INT_EN)) && !I_STACK_FULL;
               end
            end
            pwr_pkg::ST_RESTART:
            begin
               if (rs_cnt_r == `RESTART_LAST)
               begin
                  state_r <= pwr_pkg::ST_RUN;
               end
               else
               begin
                  rs_cnt_r <= rs_cnt_r + 10'h001;
               end
            end
            default:
            begin
               state_r <= pwr_pkg::ST_RESTART;
            end
         endcase
      end
   end

   // =============================================================
   // pulses to the core
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RESET_N)
      begin
         sys_rst_r <= 1'b1;
         pcsp_rst_r <= 1'b0;
         resume_r <= 1'b0;
         int_acc_r <= 1'b0;
      end
      else
      begin
         sys_rst_r <= !rst_level || (wdt_ovf && state_r == pwr_pkg::ST_RUN);
         pcsp_rst_r <= rst_level && wdt_ovf && state_r == pwr_pkg::ST_HALT;
         resume_r <= rst_level && state_r == pwr_pkg::ST_RESTART
            && rs_cnt_r == `RESTART_LAST;
         int_acc_r <= resume_r && svc_r;
      end
   end

   assign O_SYS_RESET = sys_rst_r;
   assign O_PC_SP_RESET = pcsp_rst_r;
   assign O_RESUME = resume_r;
   assign O_INT_ACCEPT = int_acc_r;
   assign O_CPU_RUN = (state_r == pwr_pkg::ST_RUN);

   // =============================================================
   // assertions
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESET_N);

   sequence s_halt_in;
      halt_take && !wdt_ovf;
   endsequence
   sequence s_flags_set;
      pdf_r && !to_r;
   endsequence

   AST_HALT_FLAGS: assert property (s_halt_in |=> s_flags_set)
      else $error("halt did not set power-down flag");
   AST_CLK_STOPPED: assert property (state_r == pwr_pkg::ST_HALT |-> !O_SYS_CLK_EN && !O_CPU_RUN)
      else $error("clock running while halted");
   AST_RESTART_BOUND: assert property (state_r == pwr_pkg::ST_RESTART && rs_cnt_r != `RESTART_LAST
      |=> state_r == pwr_pkg::ST_RESTART)
      else $error("restart left before terminal count");
   AST_RELEASE: assert property ($rose(O_CPU_RUN) |-> $past(rs_cnt_r) == `RESTART_LAST && O_RESUME)
      else $error("run released before terminal count");
   AST_PIN_WAKE: assert property (state_r == pwr_pkg::ST_HALT && rst_level && !wdt_ovf && pa_wake
      |=> state_r == pwr_pkg::ST_RESTART && wake_r == pwr_pkg::WAKE_PORT_A && !svc_r)
      else $error("pin wake missed");
   AST_WDT_WAKE: assert property (state_r == pwr_pkg::ST_HALT && rst_level && wdt_ovf
      |=> to_r && pdf_r && O_PC_SP_RESET && !O_SYS_RESET)
      else $error("halt timeout wrong");
   AST_INT_SERVICE: assert property (O_RESUME && svc_r |=> O_INT_ACCEPT)
      else $error("service not started after restart");
   AST_NO_SPURIOUS: assert property (state_r == pwr_pkg::ST_HALT && rst_level && !wdt_ovf
      && !pa_wake && int_wake == '0 |=> state_r == pwr_pkg::ST_HALT)
      else $error("halt left without wake source");
   AST_OSCILLATOR_OUTPUT_PIN_RC: assert property (!cfg_r[`CFG_OSC_RC] |-> !O_OSCILLATOR_OUTPUT_PIN_OE)
      else $error("divided clock driven in crystal mode");
   AST_CLR_PDF: assert property (clr_done && !halt_take |=> !pdf_r)
      else $error("clear did not clear power-down flag");
endmodule

//--- verification/pwr_far_side.sv
// far-side model: reset pin, port A wake pins, interrupt sources, watchdog oscillator
`timescale 1ns/100ps
module pwr_far_side (
   // clock
   input wire logic i_clk,
   // pins and interrupt state
   output logic o_ext_rst_n,
   output logic [7:0] o_port_a,
   output logic o_wdt_osc,
   output logic [3:0] o_int_req,
   output logic [3:0] o_int_en,
   output logic o_stack_full
);
   logic [1:0] div_r;
   logic [2:0] hold_r;
   // ==========
   // idle levels
   initial
   begin
      o_ext_rst_n = 1'b1;
      o_port_a = 8'hFF;
      o_int_req = 4'h0;
      o_int_en = 4'h0;
      o_stack_full = 1'b0;
      div_r = 2'h0;
      hold_r = 3'h0;
   end
   // free running, slow enough that no overflow lands inside the run
   always @(posedge i_clk)
      div_r <= div_r + 2'h1;
   assign o_wdt_osc = div_r[1];
   // pulled-up pins return high a few cycles after a fall
   always @(posedge i_clk)
      if (hold_r != 3'h0)
      begin
         hold_r <= hold_r - 3'h1;
         if (hold_r == 3'h1)
            o_port_a <= 8'hFF;
      end
   // ==========
   // stimulus tasks
   task pin_fall(input int idx);
   begin
      @(posedge i_clk);
      o_port_a[idx] <= 1'b0;
      hold_r <= 3'h4;
   end
   endtask
   task set_rst(input logic v);
   begin
      @(posedge i_clk);
      o_ext_rst_n <= v;
   end
   endtask
   task set_int(input logic [3:0] req, input logic [3:0] en, input logic full);
   begin
      @(posedge i_clk);
      o_int_req <= req;
      o_int_en <= en;
      o_stack_full <= full;
   end
   endtask
endmodule

//--- verification/power_down_wakeup_control_tb_top.sv
// self-checking bench for the power-down and wake-up controller
`timescale 1ns/100ps
`include "pwr_defines.svh"
module power_down_wakeup_control_tb_top;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, halt, clr1, clr2;
   logic [7:0] awaddr, araddr, port_a;
   logic [31:0] wdata, rdata, d, r;
   logic [3:0] wstrb, int_req, int_en;
   logic [1:0] bresp, rresp, resp;
   logic awready, wready, bvalid, arready, rvalid, ext_rst_n, wdt_osc, stack_full;
   logic od_pin, od_oe, sel_rc, clk_en, wosc_en, cpu_run, sys_reset, pcsp, resume, int_acc;
   logic power_down_flag, to, exp_pdf, exp_to;
   logic seen1, seen2, clr_two;
   int fails, total_checks, seed, cyc;
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   power_down_wakeup_control DUT (
      .I_SYS_CLK(clk), .I_RESET_N(rst_n),
      .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
      .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
      .I_EXTERNAL_RESET_PIN_N(ext_rst_n), .I_PORT_A_PIN(port_a), .I_WDT_OSC(wdt_osc),
      .O_OSCILLATOR_OUTPUT_PIN(od_pin), .O_OSCILLATOR_OUTPUT_PIN_OE(od_oe),
      .I_HALT_EXEC(halt), .I_CLR_WDT1_EXEC(clr1), .I_CLR_WDT2_EXEC(clr2),
      .I_INT_REQ(int_req), .I_INT_EN(int_en), .I_STACK_FULL(stack_full),
      .O_OSC_SEL_RC(sel_rc), .O_SYS_CLK_EN(clk_en), .O_WDT_OSC_EN(wosc_en),
      .O_CPU_RUN(cpu_run), .O_SYS_RESET(sys_reset), .O_PC_SP_RESET(pcsp),
      .O_RESUME(resume), .O_INT_ACCEPT(int_acc),
      .O_POWER_DOWN_FLAG(power_down_flag), .O_TIMEOUT_FLAG(to));
   pwr_far_side far (.i_clk(clk), .o_ext_rst_n(ext_rst_n), .o_port_a(port_a),
      .o_wdt_osc(wdt_osc), .o_int_req(int_req), .o_int_en(int_en), .o_stack_full(stack_full));
   // ==========
   // checking and ending
   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   task chk32(input logic [31:0] got, input logic [31:0] exp);
   begin
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task chk1(input logic got, input logic exp);
   begin
      chk32({31'h0, got}, {31'h0, exp});
   end
   endtask
   task hang;
   begin
      chk1(1'b0, 1'b1);
      report_and_stop;
   end
   endtask
   // ==========
   // register bus
   task axi_wr(input logic [7:0] a, input logic [31:0] dv);
      int n;
   begin
      @(posedge clk);
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         n++;
      end
      while (bvalid !== 1'b1 && n < 50);
      resp = bresp;
      bready <= 1'b0;
      if (n >= 50)
         hang;
   end
   endtask
   task axi_rd(input logic [7:0] a);
      int n;
   begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         n++;
      end
      while (rvalid !== 1'b1 && n < 50);
      r = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n >= 50)
         hang;
   end
   endtask
   task chk_status(input logic [2:0] src);
   begin
      axi_rd(`ADDR_STATUS);
      chk32(r & 32'h0000_0703, {21'h0, src, 6'h0, exp_to, exp_pdf});
   end
   endtask
   // ==========
   // core events
   task pulse(input int which);
   begin
      @(posedge clk);
      halt <= (which == 0);
      clr1 <= (which == 1);
      clr2 <= (which == 2);
      @(posedge clk);
      halt <= 1'b0;
      clr1 <= 1'b0;
      clr2 <= 1'b0;
      repeat (3) @(posedge clk);
      seen1 = seen1 || (which == 1);
      seen2 = seen2 || (which == 2);
      if (which == 0)
      begin
         exp_pdf = 1'b1;
         exp_to = 1'b0;
      end
      // two-instruction mode clears only once both have been seen
      else if (!clr_two || (seen1 && seen2))
      begin
         exp_pdf = 1'b0;
         seen1 = 1'b0;
         seen2 = 1'b0;
      end
      chk1(power_down_flag, exp_pdf);
      chk1(to, exp_to);
      chk1(clk_en, which != 0);
      chk1(cpu_run, which != 0);
   end
   endtask
   // counts restart cycles: clock on, core not yet running
   task wait_resume(input logic acc, input logic len);
      int n;
   begin
      cyc = 0;
      n = 0;
      while (resume !== 1'b1 && n < 3000)
      begin
         @(posedge clk);
         if (clk_en === 1'b1 && cpu_run === 1'b0)
            cyc++;
         n++;
      end
      if (n >= 3000)
         hang;
      if (len)
         chk32(32'(cyc), 32'h0000_0400);
      @(posedge clk);
      chk1(int_acc, acc);
      chk1(sys_reset, 1'b0);
      chk1(pcsp, 1'b0);
   end
   endtask
   // ==========
   // main sequence
   initial
   begin
      seed = 22;
      fails = 0;
      total_checks = 0;
      exp_pdf = 1'b0;
      exp_to = 1'b0;
      seen1 = 1'b0;
      seen2 = 1'b0;
      clr_two = 1'b0;
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, halt, clr1, clr2} = 8'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      wait_resume(1'b0, 1'b0);
      chk1(power_down_flag, 1'b0);
      chk1(to, 1'b0);
      axi_rd(`ADDR_CONFIG);
      chk32(r, `CFG_RESET);
      axi_rd(8'h10);
      chk32({r[31:2], resp}, {30'h0, `RESP_SLVERR});
      axi_wr(`ADDR_STATUS, 32'h0000_0003);
      chk32({30'h0, resp}, {30'h0, `RESP_SLVERR});
      chk_status(pwr_pkg::WAKE_NONE);
      // only pin 3 may wake
      axi_wr(`ADDR_CONFIG, 32'h0000_0802);
      pulse(0);
      far.pin_fall(2);
      repeat (20) @(posedge clk);
      chk1(cpu_run, 1'b0);
      far.pin_fall(3);
      wait_resume(1'b0, 1'b1);
      chk_status(pwr_pkg::WAKE_PORT_A);
      // serviced, disabled, stack full
      for (int k = 0; k < 3; k++)
      begin
         pulse(0);
         far.set_int(4'h2, (k == 1) ? 4'h0 : 4'h2, k == 2);
         wait_resume(k == 0, 1'b1);
         chk_status(pwr_pkg::WAKE_INT);
         far.set_int(4'h0, 4'h0, 1'b0);
      end
      far.set_int(4'h1, 4'h1, 1'b0);
      pulse(0);
      repeat (20) @(posedge clk);
      chk1(cpu_run, 1'b0);
      far.set_int(4'h0, 4'h0, 1'b0);
      far.pin_fall(3);
      wait_resume(1'b0, 1'b1);
      pulse(0);
      far.set_rst(1'b0);
      repeat (6) @(posedge clk);
      chk1(sys_reset, 1'b1);
      far.set_rst(1'b1);
      wait_resume(1'b0, 1'b0);
      chk_status(pwr_pkg::WAKE_EXT_RESET);
      pulse(1);
      axi_wr(`ADDR_CONFIG, 32'h0000_080A);
      clr_two = 1'b1;
      pulse(0);
      far.pin_fall(3);
      wait_resume(1'b0, 1'b1);
      pulse(1);
      pulse(1);
      pulse(2);
      for (int k = 0; k < 4; k++)
      begin
         d = $random(seed);
         axi_wr(`ADDR_CONFIG, d);
         axi_rd(`ADDR_CONFIG);
         chk32(r & 32'h0000_FF1F, d & 32'h0000_FF1F);
      end
      axi_wr(`ADDR_CONFIG, 32'h0000_0011);
      chk1(sel_rc, 1'b1);
      chk1(wosc_en, 1'b0);
      cyc = 0;
      repeat (8)
      begin
         @(posedge clk);
         if (od_oe === 1'b1)
            cyc++;
         chk1(od_pin, 1'b0);
      end
      chk32(32'(cyc), 32'h0000_0004);
      report_and_stop;
   end
endmodule
